// [design/dpll_ctrl_pkg.sv]
// constants, register map and codes for the loop reference and filter control
package dpll_ctrl_pkg;

  // register offsets
  localparam logic [7:0] ADDR_REF_SEL   = 8'h71;
  localparam logic [7:0] ADDR_STATE_OVR = 8'h72;
  localparam logic [7:0] ADDR_ACQ_FILT  = 8'h73;
  localparam logic [7:0] ADDR_LOCK_FILT = 8'h74;
  localparam logic [7:0] ADDR_LOOP_CFG6 = 8'h76;

  // values after reset
  localparam logic [7:0] RST_REF_SEL    = 8'h00;
  localparam logic [7:0] RST_STATE_OVR  = 8'h00;
  localparam logic [7:0] RST_ACQ_FILT   = 8'h6F;
  localparam logic [7:0] RST_LOCK_FILT  = 8'h6D;
  localparam logic [7:0] RST_LOOP_CFG6  = 8'h80;

  // implemented bits
  localparam logic [7:0] MASK_STATE_OVR = 8'h47;
  localparam logic [7:0] MASK_LOOP_CFG6 = 8'h80;

  // field positions
  localparam int BIT_EXT_SEL  = 7;
  localparam int BIT_ULTRAFAST_SWITCH_ENABLE     = 6;
  localparam int BIT_RETURN_TO_PREFERRED_ENABLE   = 5;
  localparam int BIT_WIDE     = 4;
  localparam int BIT_SPLIT_BW = 7;
  localparam int DAMP_LSB     = 5;

  // pinned reference codes
  localparam logic [3:0] PIN_AUTO = 4'h0;
  localparam logic [3:0] PIN_ONE  = 4'h1;
  localparam logic [3:0] PIN_TWO  = 4'h2;

  // reference identifiers
  localparam logic [1:0] REF_NONE    = 2'h0;
  localparam logic [1:0] REF_ONE     = 2'h1;
  localparam logic [1:0] REF_TWO     = 2'h2;
  localparam logic [1:0] DEFAULT_TOP = 2'h1;

  // state override
  localparam logic [2:0] OVR_AUTO   = 3'h0;
  localparam logic [2:0] OVR_UNUSED = 3'h3;

  typedef enum logic [2:0] {
    ST_FREE_RUN  = 3'b001,
    ST_HOLD      = 3'b010,
    ST_TEMP_HOLD = 3'b011,
    ST_LOCKED    = 3'b100,
    ST_PRELOCK2  = 3'b101,
    ST_PRELOCK   = 3'b110,
    ST_LOSS      = 3'b111
  } loop_state_e;

  // bandwidth codes
  localparam logic [4:0] BW_4HZ   = 5'h0D;
  localparam logic [4:0] BW_8HZ   = 5'h0E;
  localparam logic [4:0] BW_18HZ  = 5'h0F;
  localparam logic [4:0] BW_35HZ  = 5'h10;
  localparam logic [4:0] BW_400HZ = 5'h14;

  // damping codes
  localparam logic [2:0] DAMP_C1 = 3'h1;
  localparam logic [2:0] DAMP_C2 = 3'h2;
  localparam logic [2:0] DAMP_C3 = 3'h3;
  localparam logic [2:0] DAMP_C4 = 3'h4;
  localparam logic [2:0] DAMP_C5 = 3'h5;

  typedef enum logic [2:0] {
    DF_NONE = 3'b000,
    DF_1P2  = 3'b001,
    DF_2P5  = 3'b010,
    DF_5    = 3'b011,
    DF_10   = 3'b100,
    DF_20   = 3'b101
  } damp_factor_e;

  // cycle counts
  localparam logic [7:0] ULTRAFAST_SWITCH_ENABLE_MISS_CYCLES  = 8'h04;
  localparam logic [7:0] LONG_EVENT_CYCLES = 8'h40;
  localparam logic [7:0] MISS_MAX          = 8'hFF;

endpackage

// [design/dpll_filter_select.sv]
// bandwidth and damping selection for the acquisition and locked phases
`timescale 1ns/1ps
module dpll_filter_select (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // configuration
  input  wire logic       i_split_bw,
  input  wire logic       i_locked,
  input  wire logic [7:0] i_acq_cfg,
  input  wire logic [7:0] i_lock_cfg,
  // selection
  output logic      [4:0] o_bw_code,
  output logic      [2:0] o_damp_factor,
  output logic            o_cfg_unused
);

  function automatic dpll_ctrl_pkg::damp_factor_e damp_lookup(input logic [2:0] code,
                                                              input logic [4:0] bw);
    logic [2:0] col;
    col = 3'h4;
    if (bw <= dpll_ctrl_pkg::BW_4HZ) col = 3'h0;
    else if (bw == dpll_ctrl_pkg::BW_8HZ) col = 3'h1;
    else if (bw == dpll_ctrl_pkg::BW_18HZ) col = 3'h2;
    else if (bw == dpll_ctrl_pkg::BW_35HZ) col = 3'h3;
    damp_lookup = dpll_ctrl_pkg::DF_NONE;
    if (bw >= dpll_ctrl_pkg::BW_4HZ && bw <= dpll_ctrl_pkg::BW_400HZ)
    begin
      case (code)
        dpll_ctrl_pkg::DAMP_C1: damp_lookup = (col == 3'h0) ? dpll_ctrl_pkg::DF_5 :
                                 (col == 3'h1) ? dpll_ctrl_pkg::DF_2P5 : dpll_ctrl_pkg::DF_1P2;
        dpll_ctrl_pkg::DAMP_C2: damp_lookup = (col <= 3'h1) ? dpll_ctrl_pkg::DF_5 :
                                 dpll_ctrl_pkg::DF_2P5;
        dpll_ctrl_pkg::DAMP_C3: damp_lookup = dpll_ctrl_pkg::DF_5;
        dpll_ctrl_pkg::DAMP_C4: damp_lookup = (col <= 3'h2) ? dpll_ctrl_pkg::DF_5 :
                                 dpll_ctrl_pkg::DF_10;
        dpll_ctrl_pkg::DAMP_C5: damp_lookup = (col <= 3'h2) ? dpll_ctrl_pkg::DF_5 :
                                 (col == 3'h3) ? dpll_ctrl_pkg::DF_10 : dpll_ctrl_pkg::DF_20;
        default: damp_lookup = dpll_ctrl_pkg::DF_NONE;
      endcase
    end
  endfunction

  logic                        use_acq;
  logic                  [4:0] bw_d;
  dpll_ctrl_pkg::damp_factor_e damp_d;

  // acquisition settings only while pulling in, and only when split mode is on
  assign use_acq = i_split_bw && !i_locked;
  assign bw_d    = use_acq ? i_acq_cfg[4:0] : i_lock_cfg[4:0];
  assign damp_d  = use_acq ? damp_lookup(i_acq_cfg[7:dpll_ctrl_pkg::DAMP_LSB], i_acq_cfg[4:0])
                           : damp_lookup(i_lock_cfg[7:dpll_ctrl_pkg::DAMP_LSB],
                                         i_lock_cfg[4:0]);

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bw_code     <= dpll_ctrl_pkg::BW_4HZ;
      o_damp_factor <= dpll_ctrl_pkg::DF_5;
      o_cfg_unused  <= 1'b0;
    end
    else
    begin
      o_bw_code     <= bw_d;
      o_damp_factor <= damp_d;
      o_cfg_unused  <= (damp_d == dpll_ctrl_pkg::DF_NONE);
    end
  end

  a_bw_lock_phase: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_locked |=> o_bw_code == $past(i_lock_cfg[4:0]))
    else $error("locked phase did not use locked bandwidth");

  a_damp_c3_five: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_locked && i_lock_cfg == dpll_ctrl_pkg::RST_LOCK_FILT) |=> o_damp_factor == 3'b011)
    else $error("reset locked damping code did not give factor five");

endmodule

// [design/dpll_ref_loop_ctrl.sv]
// reference selection, loop state control and filter configuration registers
// Summary of operation
// - registers answer only while the master clock is present.
// - with the loop disabled all loop fields are ignored.
// - pin selection mode follows the select pin regardless of validity.
// - ultra-fast switching disqualifies the selected input after few missing cycles.
// - revertive mode selects a newly valid higher priority input at once.
// - wide tracking bit turns the plus or minus 160 ppm range on.
// - pinned field 0 auto, 1 input one, 2 input two, rest unused.
// - pinning gives top priority; revertive mode also selects it.
// - nonrevertive pinned input is selected once the current one fails.
// - pinned input stays selected even when declared invalid.
// - short loss gives temporary hold, long loss gives full hold.
// - pinned field is ignored by selection in pin selection mode; top priority still follows it.
// - nonzero override other than 3 holds the state machine; zero and 3 restore automatic.
// - override codes map to free-run, hold, locked, prelocked, loss states.
// - acquisition damping depends on damping code and acquisition bandwidth.
// - acquisition bandwidth codes span 4 to 400 Hz, 18 Hz after reset.
// - split bandwidth uses acquisition bandwidth while pulling in only.
// - locked damping uses the same table; reset code gives five.
// - locked bandwidth uses the same codes, 4 Hz after reset.
// - split bandwidth bit resets to one.
`timescale 1ns/1ps
module dpll_ref_loop_ctrl (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr_en,
  input  wire logic       i_reg_rd_en,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_ack,
  // device level control
  input  wire logic       i_mclk_present,
  input  wire logic       i_digital_loop_enable,
  // reference inputs
  input  wire logic       i_ext_select_pin,
  input  wire logic [1:0] i_ref_valid,
  input  wire logic [1:0] i_ref_active,
  // loop events
  input  wire logic       i_phase_locked,
  input  wire logic       i_lock_lost,
  // loop control outputs
  output logic      [1:0] o_selected_ref,
  output logic      [1:0] o_top_priority_ref,
  output logic      [2:0] o_loop_state,
  output logic            o_wide_tracking_range_enable,
  output logic      [1:0] o_ref_disqualified,
  output logic      [4:0] o_bw_code,
  output logic      [2:0] o_damp_factor,
  output logic            o_filter_cfg_unused
);

  function automatic logic ref_ok(input logic [1:0] r, input logic [1:0] q);
    ref_ok = (r == dpll_ctrl_pkg::REF_ONE) ? q[0] :
             (r == dpll_ctrl_pkg::REF_TWO) ? q[1] : 1'b0;
  endfunction

  function automatic logic [1:0] other_ref(input logic [1:0] r);
    other_ref = (r == dpll_ctrl_pkg::REF_ONE) ? dpll_ctrl_pkg::REF_TWO : dpll_ctrl_pkg::REF_ONE;
  endfunction

  logic [7:0] ref_sel_q;
  logic [7:0] state_ovr_q;
  logic [7:0] acq_filt_q;
  logic [7:0] lock_filt_q;
  logic [7:0] loop_cfg6_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] pin_stable_q;
  logic       mclk_ok;
  logic       sel_pin;
  logic       access_ok;
  logic       en;
  logic [7:0] cfg1;
  logic [7:0] cfg2;
  logic [7:0] cfg3;
  logic [7:0] cfg4;
  logic       split_bw;
  logic [7:0] miss_q [2];
  logic [1:0] qual;
  logic [1:0] pin_ref;
  logic [1:0] top;
  logic [1:0] sel_d;
  logic [1:0] top_d;
  logic [7:0] miss_sel;
  logic       was_locked_q;
  dpll_ctrl_pkg::loop_state_e state_q;
  dpll_ctrl_pkg::loop_state_e state_d;

  // select pin and clock-present flag come from outside: three stages, agreement of last two
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_q      <= 2'h0;
      sync2_q      <= 2'h0;
      sync3_q      <= 2'h0;
      pin_stable_q <= 2'h0;
    end
    else
    begin
      sync1_q <= {i_mclk_present, i_ext_select_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int k = 0; k < 2; k++)
      begin
        if (sync2_q[k] == sync3_q[k])
          pin_stable_q[k] <= sync3_q[k];
      end
    end
  end

  assign sel_pin   = pin_stable_q[0];
  assign mclk_ok   = pin_stable_q[1];
  assign access_ok = (i_reg_wr_en || i_reg_rd_en) && mclk_ok;

  // register writes; unimplemented bits are masked off
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ref_sel_q   <= dpll_ctrl_pkg::RST_REF_SEL;
      state_ovr_q <= dpll_ctrl_pkg::RST_STATE_OVR;
      acq_filt_q  <= dpll_ctrl_pkg::RST_ACQ_FILT;
      lock_filt_q <= dpll_ctrl_pkg::RST_LOCK_FILT;
      loop_cfg6_q <= dpll_ctrl_pkg::RST_LOOP_CFG6;
    end
    else if (i_reg_wr_en && mclk_ok)
    begin
      case (i_reg_addr)
        dpll_ctrl_pkg::ADDR_REF_SEL:   ref_sel_q   <= i_reg_wdata;
        dpll_ctrl_pkg::ADDR_STATE_OVR: state_ovr_q <= i_reg_wdata & dpll_ctrl_pkg::MASK_STATE_OVR;
        dpll_ctrl_pkg::ADDR_ACQ_FILT:  acq_filt_q  <= i_reg_wdata;
        dpll_ctrl_pkg::ADDR_LOCK_FILT: lock_filt_q <= i_reg_wdata;
        dpll_ctrl_pkg::ADDR_LOOP_CFG6: loop_cfg6_q <= i_reg_wdata & dpll_ctrl_pkg::MASK_LOOP_CFG6;
        default: ;
      endcase
    end
  end

  // read data and acknowledge; unmapped addresses read zero
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_ack   <= 1'b0;
    end
    else
    begin
      o_reg_ack <= access_ok;
      if (i_reg_rd_en && mclk_ok)
      begin
        case (i_reg_addr)
          dpll_ctrl_pkg::ADDR_REF_SEL:   o_reg_rdata <= ref_sel_q;
          dpll_ctrl_pkg::ADDR_STATE_OVR: o_reg_rdata <= state_ovr_q;
          dpll_ctrl_pkg::ADDR_ACQ_FILT:  o_reg_rdata <= acq_filt_q;
          dpll_ctrl_pkg::ADDR_LOCK_FILT: o_reg_rdata <= lock_filt_q;
          dpll_ctrl_pkg::ADDR_LOOP_CFG6: o_reg_rdata <= loop_cfg6_q;
          default:                       o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // a disabled loop sees only reset values, so stored fields have no effect
  assign en       = i_digital_loop_enable;
  assign cfg1     = en ? ref_sel_q   : dpll_ctrl_pkg::RST_REF_SEL;
  assign cfg2     = en ? state_ovr_q : dpll_ctrl_pkg::RST_STATE_OVR;
  assign cfg3     = en ? acq_filt_q  : dpll_ctrl_pkg::RST_ACQ_FILT;
  assign cfg4     = en ? lock_filt_q : dpll_ctrl_pkg::RST_LOCK_FILT;
  assign split_bw = en ? loop_cfg6_q[dpll_ctrl_pkg::BIT_SPLIT_BW] : 1'b1;

  // missing-cycle counters feed both ultra-fast disqualification and hold decisions
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_miss
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
          miss_q[gi] <= 8'h00;
        else if (i_ref_active[gi])
          miss_q[gi] <= 8'h00;
        else if (miss_q[gi] != dpll_ctrl_pkg::MISS_MAX)
          miss_q[gi] <= miss_q[gi] + 8'h01;
      end
      assign o_ref_disqualified[gi] = cfg1[dpll_ctrl_pkg::BIT_ULTRAFAST_SWITCH_ENABLE] &&
                                      miss_q[gi] >= dpll_ctrl_pkg::ULTRAFAST_SWITCH_ENABLE_MISS_CYCLES;
      assign qual[gi] = i_ref_valid[gi] && !o_ref_disqualified[gi];
    end
  endgenerate

  // unused pinned codes fall back to automatic selection
  assign pin_ref = (cfg1[3:0] == dpll_ctrl_pkg::PIN_ONE) ? dpll_ctrl_pkg::REF_ONE :
                   (cfg1[3:0] == dpll_ctrl_pkg::PIN_TWO) ? dpll_ctrl_pkg::REF_TWO :
                   dpll_ctrl_pkg::REF_NONE;
  assign top      = (pin_ref != dpll_ctrl_pkg::REF_NONE) ? pin_ref : dpll_ctrl_pkg::DEFAULT_TOP;
  assign miss_sel = (o_selected_ref == dpll_ctrl_pkg::REF_TWO) ? miss_q[1] : miss_q[0];

  always_comb
  begin
    sel_d = o_selected_ref;
    if (!en)
      sel_d = dpll_ctrl_pkg::REF_NONE;
    else if (cfg1[dpll_ctrl_pkg::BIT_EXT_SEL])
      sel_d = sel_pin ? dpll_ctrl_pkg::REF_ONE : dpll_ctrl_pkg::REF_TWO;
    else if (pin_ref != dpll_ctrl_pkg::REF_NONE)
    begin
      // a pinned input is never abandoned, even when invalid
      if (cfg1[dpll_ctrl_pkg::BIT_RETURN_TO_PREFERRED_ENABLE] || !ref_ok(o_selected_ref, qual))
        sel_d = pin_ref;
    end
    else if (cfg1[dpll_ctrl_pkg::BIT_RETURN_TO_PREFERRED_ENABLE] || !ref_ok(o_selected_ref, qual))
      sel_d = ref_ok(top, qual) ? top :
              ref_ok(other_ref(top), qual) ? other_ref(top) : dpll_ctrl_pkg::REF_NONE;
  end

  assign top_d = !en ? dpll_ctrl_pkg::REF_NONE :
                 (pin_ref != dpll_ctrl_pkg::REF_NONE) ? pin_ref :
                 ref_ok(top, qual) ? top :
                 ref_ok(other_ref(top), qual) ? other_ref(top) : top;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_selected_ref               <= dpll_ctrl_pkg::REF_NONE;
      o_top_priority_ref           <= dpll_ctrl_pkg::REF_NONE;
      o_wide_tracking_range_enable <= 1'b0;
    end
    else
    begin
      o_selected_ref               <= sel_d;
      o_top_priority_ref           <= top_d;
      o_wide_tracking_range_enable <= cfg1[dpll_ctrl_pkg::BIT_WIDE];
    end
  end

  always_comb
  begin
    state_d = state_q;
    if (!en)
      state_d = dpll_ctrl_pkg::ST_FREE_RUN;
    else if (cfg2[2:0] != dpll_ctrl_pkg::OVR_AUTO && cfg2[2:0] != dpll_ctrl_pkg::OVR_UNUSED)
      state_d = dpll_ctrl_pkg::loop_state_e'(cfg2[2:0]);
    else if (o_selected_ref == dpll_ctrl_pkg::REF_NONE)
      state_d = was_locked_q ? dpll_ctrl_pkg::ST_HOLD : dpll_ctrl_pkg::ST_FREE_RUN;
    else if (miss_sel >= dpll_ctrl_pkg::LONG_EVENT_CYCLES)
      state_d = dpll_ctrl_pkg::ST_HOLD;
    else if (miss_sel != 8'h00)
      state_d = dpll_ctrl_pkg::ST_TEMP_HOLD;
    else if (sel_d != o_selected_ref)
      state_d = dpll_ctrl_pkg::ST_PRELOCK;
    else
    begin
      case (state_q)
        dpll_ctrl_pkg::ST_FREE_RUN,
        dpll_ctrl_pkg::ST_HOLD:
          if (ref_ok(o_selected_ref, qual))
            state_d = dpll_ctrl_pkg::ST_PRELOCK;
        dpll_ctrl_pkg::ST_TEMP_HOLD:
          state_d = !ref_ok(o_selected_ref, qual) ? dpll_ctrl_pkg::ST_HOLD :
                    was_locked_q ? dpll_ctrl_pkg::ST_LOCKED : dpll_ctrl_pkg::ST_PRELOCK;
        dpll_ctrl_pkg::ST_PRELOCK,
        dpll_ctrl_pkg::ST_PRELOCK2:
          if (i_phase_locked)
            state_d = dpll_ctrl_pkg::ST_LOCKED;
        dpll_ctrl_pkg::ST_LOCKED:
          if (i_lock_lost)
            state_d = dpll_ctrl_pkg::ST_LOSS;
        dpll_ctrl_pkg::ST_LOSS:
          state_d = dpll_ctrl_pkg::ST_PRELOCK2;
        default:
          state_d = dpll_ctrl_pkg::ST_FREE_RUN;
      endcase
    end
  end

  // holdover with no selected input needs a prior lock; without one there is no frequency history to keep
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q      <= dpll_ctrl_pkg::ST_FREE_RUN;
      was_locked_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (!en)
        was_locked_q <= 1'b0;
      else if (state_q == dpll_ctrl_pkg::ST_LOCKED)
        was_locked_q <= 1'b1;
    end
  end

  assign o_loop_state = state_q;

  dpll_filter_select u_filter (
    .i_clock       (i_clock),
    .i_rst_n       (i_rst_n),
    .i_split_bw    (split_bw),
    .i_locked      (state_q == dpll_ctrl_pkg::ST_LOCKED),
    .i_acq_cfg     (cfg3),
    .i_lock_cfg    (cfg4),
    .o_bw_code     (o_bw_code),
    .o_damp_factor (o_damp_factor),
    .o_cfg_unused  (o_filter_cfg_unused)
  );

  sequence s_top_priority_ref_gone;
    (!i_ref_active[0] && en && cfg1[dpll_ctrl_pkg::BIT_ULTRAFAST_SWITCH_ENABLE])[*5];
  endsequence

  a_no_clock_access: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !mclk_ok |=> !o_reg_ack)
    else $error("register answered without master clock");

  a_disabled_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !en |=> o_selected_ref == 2'h0 && o_loop_state == 3'b001)
    else $error("disabled loop not idle");

  a_ext_pin_follow: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (en && cfg1[7]) |=> o_selected_ref == ($past(sel_pin) ? 2'h1 : 2'h2))
    else $error("pin selection not followed");

  a_ultrafast_switch_enable_disqualify: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_top_priority_ref_gone |-> o_ref_disqualified[0])
    else $error("missing input not disqualified");

  a_return_to_preferred_enable_pinned: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (en && !cfg1[7] && cfg1[5] && cfg1[3:0] == 4'h2) |=> o_selected_ref == 2'h2)
    else $error("pinned input not selected in revertive mode");

  a_nonrevert_keep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (en && !cfg1[7] && !cfg1[5] && pin_ref != 2'h0 && ref_ok(o_selected_ref, qual))
    |=> $stable(o_selected_ref))
    else $error("valid selection displaced in nonrevertive mode");

  a_override_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (en && cfg2[2:0] == 3'h4) [*2] |-> o_loop_state == 3'b100)
    else $error("override did not hold locked state");

  a_short_loss_temp: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (en && cfg2[2:0] == 3'h0 && o_selected_ref != 2'h0 && miss_sel != 8'h00 &&
     miss_sel < 8'h40) |=> o_loop_state == 3'b011)
    else $error("short loss did not give temporary hold");

  a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_reg_rd_en && mclk_ok && i_reg_addr == 8'h72) |=> (o_reg_rdata & 8'hB8) == 8'h00)
    else $error("unassigned bits read nonzero");

endmodule

// [sim/ref_source_model.sv]
// partner model: two reference inputs with validity and activity, plus the select pin
`timescale 1ns/1ps
module ref_source_model (
  // clock
  input  wire logic       i_clock,
  // commands from the bench
  input  wire logic [1:0] i_valid_cmd,
  input  wire logic [1:0] i_active_cmd,
  input  wire logic       i_pin_cmd,
  // towards the block
  output logic      [1:0] o_ref_valid,
  output logic      [1:0] o_ref_active,
  output logic            o_select_pin
);
  // monitors report on the clock edge, so their levels move just after it
  always_ff @(posedge i_clock)
  begin
    o_ref_valid  <= i_valid_cmd;
    o_ref_active <= i_active_cmd;
  end

  // the select pin is a board-level strap, not tied to the clock
  assign o_select_pin = i_pin_cmd;
endmodule

// [sim/test_dpll_ref_loop_ctrl.sv]
// self-checking bench for the loop reference and filter control block
`timescale 1ns/1ps
module test_dpll_ref_loop_ctrl;
  logic       i_clock, i_rst_n, wr, rd, mclk, en, plk, lost, pcmd, pin, ack, wide, unused;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] vcmd, acmd, valid, active, sel, top, disq;
  logic [2:0] state, damp;
  logic [4:0] bw;
  logic [7:0] rows [6][3];
  logic [2:0] codes [6];
  int         failures, tests_run, cycles;

  ref_source_model u_src (.i_clock(i_clock), .i_valid_cmd(vcmd), .i_active_cmd(acmd),
    .i_pin_cmd(pcmd), .o_ref_valid(valid), .o_ref_active(active), .o_select_pin(pin));

  dpll_ref_loop_ctrl u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(addr),
    .i_reg_wr_en(wr), .i_reg_rd_en(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .i_mclk_present(mclk), .i_digital_loop_enable(en),
    .i_ext_select_pin(pin), .i_ref_valid(valid), .i_ref_active(active),
    .i_phase_locked(plk), .i_lock_lost(lost), .o_selected_ref(sel),
    .o_top_priority_ref(top), .o_loop_state(state), .o_wide_tracking_range_enable(wide),
    .o_ref_disqualified(disq), .o_bw_code(bw), .o_damp_factor(damp),
    .o_filter_cfg_unused(unused));

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one access; a refused access must stay silent
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d,
                        input logic [7:0] exp, input logic want_ack);
    @(posedge i_clock);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge i_clock);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    check("ack", {7'h00, want_ack}, {7'h00, ack});
    if (!w && want_ack)
      check("rdata", exp, rdata);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic give_verdict();
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    {wr, rd, en, plk, lost, pcmd, i_rst_n} = '0;
    {addr, wdata, vcmd, acmd} = '0;
    mclk = 1'b1;
    rows = '{'{8'h72, 8'hFF, 8'h47}, '{8'h72, 8'h40, 8'h40}, '{8'h73, 8'h8F, 8'h8F},
             '{8'h76, 8'h00, 8'h00}, '{8'h76, 8'h80, 8'h80}, '{8'h71, 8'h10, 8'h10}};
    codes = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    settle(5);
    access(8'h72, 1'b0, 8'h00, 8'h00, 1'b1);
    access(8'h73, 1'b0, 8'h00, 8'h6F, 1'b1);
    access(8'h74, 1'b0, 8'h00, 8'h6D, 1'b1);
    access(8'h76, 1'b0, 8'h00, 8'h80, 1'b1);
    access(8'h75, 1'b0, 8'h00, 8'h00, 1'b1);
    foreach (rows[i])
    begin
      access(rows[i][0], 1'b1, rows[i][1], 8'h00, 1'b1);
      access(rows[i][0], 1'b0, 8'h00, rows[i][2], 1'b1);
    end
    check("wide off", 8'h00, {7'h00, wide});
    @(posedge i_clock) en <= 1'b1;
    settle(2);
    check("wide on", 8'h01, {7'h00, wide});
    access(8'h73, 1'b1, 8'hB4, 8'h00, 1'b1);
    settle(2);
    check("acq damp", 8'h05, {5'h00, damp});
    check("acq bw", 8'h14, {3'h0, bw});
    access(8'h73, 1'b1, 8'h14, 8'h00, 1'b1);
    settle(2);
    check("damp unused", 8'h01, {7'h00, unused});
    access(8'h76, 1'b1, 8'h00, 8'h00, 1'b1);
    settle(2);
    check("split off", 8'h0D, {3'h0, bw});
    check("lock damp", 8'h03, {5'h00, damp});
    access(8'h76, 1'b1, 8'h80, 8'h00, 1'b1);
    @(posedge i_clock) mclk <= 1'b0;
    settle(5);
    access(8'h73, 1'b1, 8'h6F, 8'h00, 1'b0);
    access(8'h73, 1'b0, 8'h00, 8'h00, 1'b0);
    @(posedge i_clock) mclk <= 1'b1;
    settle(5);
    access(8'h73, 1'b0, 8'h00, 8'h14, 1'b1);
    @(posedge i_clock) vcmd <= 2'b10;
    acmd <= 2'b11;
    access(8'h71, 1'b1, 8'h20, 8'h00, 1'b1);
    settle(3);
    check("sel two", 8'h02, {6'h00, sel});
    @(posedge i_clock) vcmd <= 2'b11;
    settle(3);
    check("return_to_preferred_enable", 8'h01, {6'h00, sel});
    access(8'h71, 1'b1, 8'h00, 8'h00, 1'b1);
    @(posedge i_clock) vcmd <= 2'b10;
    settle(3);
    @(posedge i_clock) vcmd <= 2'b11;
    settle(3);
    check("no return_to_preferred_enable", 8'h02, {6'h00, sel});
    check("top entry", 8'h01, {6'h00, top});
    access(8'h71, 1'b1, 8'h01, 8'h00, 1'b1);
    settle(3);
    check("pin waits", 8'h02, {6'h00, sel});
    @(posedge i_clock) vcmd <= 2'b01;
    settle(3);
    check("pin taken", 8'h01, {6'h00, sel});
    @(posedge i_clock) vcmd <= 2'b00;
    settle(3);
    check("pin kept", 8'h01, {6'h00, sel});
    @(posedge i_clock) vcmd <= 2'b11;
    access(8'h71, 1'b1, 8'h22, 8'h00, 1'b1);
    settle(3);
    check("pin return_to_preferred_enable", 8'h02, {6'h00, sel});
    @(posedge i_clock) vcmd <= 2'b00;
    pcmd <= 1'b1;
    access(8'h71, 1'b1, 8'h82, 8'h00, 1'b1);
    settle(6);
    check("ext high", 8'h01, {6'h00, sel});
    @(posedge i_clock) pcmd <= 1'b0;
    settle(6);
    check("ext low", 8'h02, {6'h00, sel});
    @(posedge i_clock) vcmd <= 2'b11;
    access(8'h71, 1'b1, 8'h40, 8'h00, 1'b1);
    settle(3);
    @(posedge i_clock) acmd <= 2'b10;
    settle(8);
    check("ultrafast_switch_enable", 8'h01, {6'h00, disq});
    @(posedge i_clock) acmd <= 2'b11;
    access(8'h71, 1'b1, 8'h00, 8'h00, 1'b1);
    settle(3);
    @(posedge i_clock) plk <= 1'b1;
    settle(3);
    check("locked", 8'h04, {5'h00, state});
    check("lock bw", 8'h0D, {3'h0, bw});
    @(posedge i_clock) plk <= 1'b0;
    acmd <= 2'b01;
    settle(3);
    check("temp hold", 8'h03, {5'h00, state});
    settle(66);
    check("full hold", 8'h02, {5'h00, state});
    @(posedge i_clock) acmd <= 2'b11;
    foreach (codes[i])
    begin
      access(8'h72, 1'b1, {5'h08, codes[i]}, 8'h00, 1'b1);
      @(posedge i_clock) lost <= 1'b1;
      settle(2);
      check("override", {5'h00, codes[i]}, {5'h00, state});
      @(posedge i_clock) lost <= 1'b0;
    end
    access(8'h72, 1'b1, 8'h43, 8'h00, 1'b1);
    settle(2);
    check("override unused", 8'h05, {5'h00, state});
    access(8'h72, 1'b1, 8'h40, 8'h00, 1'b1);
    @(posedge i_clock) en <= 1'b0;
    settle(2);
    check("disabled", 8'h00, {6'h00, sel});
    @(posedge i_clock) i_rst_n <= 1'b0;
    settle(2);
    check("reset bw", 8'h0D, {3'h0, bw});
    check("reset damp", 8'h03, {5'h00, damp});
    @(posedge i_clock) i_rst_n <= 1'b1;
    settle(5);
    access(8'h72, 1'b0, 8'h00, 8'h00, 1'b1);
    access(8'h73, 1'b0, 8'h00, 8'h6F, 1'b1);
    give_verdict();
  end
endmodule
